// >>> src/fcc_params.svh
`ifndef FCC_PARAMS_SVH
`define FCC_PARAMS_SVH
`define FCC_OP_FP_COPROCESSOR_MAJOR_OPCODE 6'h11
`define FCC_FN_ROUND_UP_TO_INT64 6'h0A
`define FCC_FN_ROUND_UP_TO_INT32 6'h0E
`define FCC_SUB_CF 5'h02
`define FCC_FMT_S 5'h10
`define FCC_FMT_D 5'h11
`define FCC_SEL_FIR 5'h00
`define FCC_SEL_CCR 5'h19
`define FCC_SEL_EXR 5'h1A
`define FCC_SEL_ENR 5'h1C
`define FCC_SEL_CSR 5'h1F
`define FCC_BIT_INX_FLAG 2
`define FCC_BIT_INV_FLAG 6
`define FCC_BIT_INV_EN 11
`define FCC_BIT_OVF_FLAG 4
`define FCC_BIT_INX_CAUSE 12
`define FCC_BIT_OVF_CAUSE 14
`define FCC_BIT_INV_CAUSE 16
`define FCC_BIT_UNI_CAUSE 17
`define FCC_MAX_L 64'h7FFFFFFFFFFFFFFF
`define FCC_MAX_W 32'h7FFFFFFF
`define FCC_FIR_VALUE 32'h00000000
`endif

// >>> src/fcc_pkg.sv
package fcc_pkg;
  // Which operation the current instruction asks for
  typedef enum logic [3:0] {
    FCC_OP_NONE = 4'h1,
    FCC_OP_ROUND_UP_TO_INT64 = 4'h2,
    FCC_OP_ROUND_UP_TO_INT32 = 4'h4,
    FCC_OP_READ_CTL = 4'h8
  } fcc_op_t;
endpackage

// >>> src/fcc_ceil.sv
`timescale 1ns/10ps
`include "fcc_params.svh"
// Combinational ceiling converter of single or double to int64/int32
module fcc_ceil (
  // Operand
  input wire logic [63:0] i_src,
  input wire logic i_is_double,
  input wire logic i_to_word,
  // Result
  output logic [63:0] o_value,
  output logic o_invalid,
  output logic o_inexact
);
  logic sign;
  logic [11:0] exp_u;
  logic [52:0] mant;
  logic nan_inf;
  logic signed [12:0] e;
  logic [116:0] wide;
  logic [63:0] ipart;
  logic frac_nz;
  logic [63:0] mag;
  logic ovf;

  // Unpack, shift mantissa to integer position, round up positives
  always_comb begin
    sign = i_is_double ? i_src[63] : i_src[31];
    exp_u = i_is_double ? {1'b0, i_src[62:52]} : {4'h0, i_src[30:23]};
    nan_inf = i_is_double ? (i_src[62:52] == 11'h7FF)
                          : (i_src[30:23] == 8'hFF);
    if (i_is_double) begin
      mant = {(i_src[62:52] != 11'h000), i_src[51:0]};
      e = $signed({1'b0, exp_u}) - 13'sd1075;
    end else begin
      mant = {(i_src[30:23] != 8'h00), i_src[22:0], 29'h0};
      e = $signed({1'b0, exp_u}) - 13'sd179;
    end
    wide = 117'h0;
    ipart = 64'h0;
    frac_nz = 1'b0;
    ovf = 1'b0;
    // Shift of 11 still fits 64 bits, so -2^63 reaches the range check
    if (e >= 13'sd12) begin
      ovf = (mant != 53'h0);
    end else if (e >= 13'sd0) begin
      wide = {64'h0, mant} << e[3:0];
      ipart = wide[63:0];
    end else if (e > -13'sd54) begin
      wide = {mant, 64'h0} >> (-e);
      ipart = {11'h0, wide[116:64]};
      frac_nz = (wide[63:0] != 64'h0);
    end else begin
      frac_nz = (mant != 53'h0);
    end
    // Round toward plus infinity: bump magnitude of positives only
    mag = ipart + {63'h0, (frac_nz & ~sign)};
    if (i_to_word)
      ovf = ovf | (sign ? (mag > 64'h80000000) : (mag > 64'h7FFFFFFF));
    else
      ovf = ovf | (sign ? (mag > 64'h8000000000000000)
                        : (mag > 64'h7FFFFFFFFFFFFFFF));
    o_invalid = nan_inf | ovf;
    o_inexact = frac_nz & ~o_invalid;
    o_value = sign ? (64'h0 - mag) : mag;
    if (i_to_word)
      o_value = {32'h0, o_value[31:0]};
  end
endmodule

// >>> src/fcc_top.sv
`timescale 1ns/10ps
`include "fcc_params.svh"
// FP ceiling conversions and control-word read slice
module fcc_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Instruction issue
  input wire logic i_valid,
  input wire logic [31:0] i_instr,
  input wire logic i_fp_coprocessor_major_opcode_usable,
  input wire logic i_fr64,
  // Operands and state
  input wire logic [63:0] i_fs_value,
  input wire logic [31:0] i_fp_control_status_register,
  // Results
  output logic o_done,
  output fcc_pkg::fcc_op_t o_op,
  output logic o_fpr_we,
  output logic [4:0] o_fpr_addr,
  output logic [63:0] o_fpr_data,
  output logic o_gpr_we,
  output logic [4:0] o_gpr_addr,
  output logic [31:0] o_gpr_data,
  // Status updates and exceptions
  output logic o_fp_control_status_register_we,
  output logic [31:0] o_fp_control_status_register_next,
  output logic o_exc_cop_unusable,
  output logic o_exc_reserved,
  output logic o_exc_invalid,
  output logic o_exc_unimpl
);
  import fcc_pkg::*;

  // All registered state of the slice
  typedef struct packed {
    logic done;
    fcc_op_t op;
    logic fpr_we;
    logic [4:0] fpr_addr;
    logic [63:0] fpr_data;
    logic gpr_we;
    logic [4:0] gpr_addr;
    logic [31:0] gpr_data;
    logic fp_control_status_register_we;
    logic [31:0] fp_control_status_register_next;
    logic exc_cu;
    logic exc_ri;
    logic exc_inv;
    logic exc_uni;
  } fcc_state_t;

  fcc_state_t st;
  fcc_state_t next_st;

  // Instruction fields
  logic [5:0] f_major;
  logic [4:0] f_fmt;
  logic [4:0] f_mid;
  logic [4:0] source_fp_register_field;
  logic [4:0] dest_fp_register_field;
  logic [4:0] target_general_register_field;
  logic [5:0] f_func;
  logic is_fp;
  logic fmt_ok;
  fcc_op_t dec_op;
  // Converter outputs
  logic [63:0] cv_value;
  logic cv_invalid;
  logic cv_inexact;

  assign f_major = i_instr[31:26];
  assign f_fmt = i_instr[25:21];
  assign f_mid = i_instr[20:16];
  assign target_general_register_field = i_instr[20:16];
  assign source_fp_register_field = i_instr[15:11];
  assign dest_fp_register_field = i_instr[10:6];
  assign f_func = i_instr[5:0];
  assign is_fp = (f_major == `FCC_OP_FP_COPROCESSOR_MAJOR_OPCODE);
  assign fmt_ok = (f_fmt == `FCC_FMT_S) || (f_fmt == `FCC_FMT_D);

  // Decode the three supported instructions
  always_comb begin
    dec_op = FCC_OP_NONE;
    if (is_fp && f_mid == 5'h00 && fmt_ok) begin
      if (f_func == `FCC_FN_ROUND_UP_TO_INT64)
        dec_op = FCC_OP_ROUND_UP_TO_INT64;
      else if (f_func == `FCC_FN_ROUND_UP_TO_INT32)
        dec_op = FCC_OP_ROUND_UP_TO_INT32;
    end
    if (is_fp && f_fmt == `FCC_SUB_CF && i_instr[10:0] == 11'h000)
      dec_op = FCC_OP_READ_CTL;
  end

  // Shared ceiling converter
  fcc_ceil u_ceil (
    .i_src(i_fs_value),
    .i_is_double(f_fmt == `FCC_FMT_D),
    .i_to_word(dec_op == FCC_OP_ROUND_UP_TO_INT32),
    .o_value(cv_value),
    .o_invalid(cv_invalid),
    .o_inexact(cv_inexact)
  );

  // Next-state logic for one issued instruction per cycle
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.op = FCC_OP_NONE;
    next_st.fpr_we = 1'b0;
    next_st.gpr_we = 1'b0;
    next_st.fp_control_status_register_we = 1'b0;
    next_st.exc_cu = 1'b0;
    next_st.exc_ri = 1'b0;
    next_st.exc_inv = 1'b0;
    next_st.exc_uni = 1'b0;
    if (i_valid && is_fp) begin
      next_st.done = 1'b1;
      next_st.op = dec_op;
      if (!i_fp_coprocessor_major_opcode_usable) begin
        // Unusable coprocessor wins over everything else
        next_st.exc_cu = 1'b1;
      end else begin
        case (dec_op)
          FCC_OP_ROUND_UP_TO_INT64, FCC_OP_ROUND_UP_TO_INT32: begin
            next_st.fpr_addr = dest_fp_register_field;
            next_st.fp_control_status_register_next = i_fp_control_status_register;
            next_st.fp_control_status_register_next[`FCC_BIT_UNI_CAUSE] = 1'b0;
            next_st.fp_control_status_register_next[`FCC_BIT_INV_CAUSE] = cv_invalid;
            next_st.fp_control_status_register_next[`FCC_BIT_INX_CAUSE] = cv_inexact;
            next_st.fp_control_status_register_next[`FCC_BIT_OVF_CAUSE] = 1'b0;
            next_st.fp_control_status_register_we = 1'b1;
            if (dec_op == FCC_OP_ROUND_UP_TO_INT64 && !i_fr64) begin
              // Sixteen-register mode: no result, report unimplemented
              next_st.exc_uni = 1'b1;
              next_st.fp_control_status_register_next[`FCC_BIT_UNI_CAUSE] = 1'b1;
              next_st.fp_control_status_register_next[`FCC_BIT_INV_CAUSE] = 1'b0;
              next_st.fp_control_status_register_next[`FCC_BIT_INX_CAUSE] = 1'b0;
            end else if (cv_invalid) begin
              next_st.fp_control_status_register_next[`FCC_BIT_INV_FLAG] = 1'b1;
              if (i_fp_control_status_register[`FCC_BIT_INV_EN]) begin
                // Trap now, destination untouched
                next_st.exc_inv = 1'b1;
              end else begin
                next_st.fpr_we = 1'b1;
                next_st.fpr_data = (dec_op == FCC_OP_ROUND_UP_TO_INT64) ?
                  `FCC_MAX_L : {32'h0, `FCC_MAX_W};
              end
            end else begin
              next_st.fpr_we = 1'b1;
              next_st.fpr_data = cv_value;
              if (cv_inexact)
                next_st.fp_control_status_register_next[`FCC_BIT_INX_FLAG] = 1'b1;
            end
          end
          FCC_OP_READ_CTL: begin
            next_st.gpr_we = 1'b1;
            next_st.gpr_addr = target_general_register_field;
            case (source_fp_register_field)
              `FCC_SEL_FIR: next_st.gpr_data = `FCC_FIR_VALUE;
              `FCC_SEL_CCR:
                next_st.gpr_data = {24'h0, i_fp_control_status_register[31:25], i_fp_control_status_register[23]};
              `FCC_SEL_EXR:
                next_st.gpr_data = {14'h0, i_fp_control_status_register[17:12], 5'h00,
                                    i_fp_control_status_register[6:2], 2'h0};
              `FCC_SEL_ENR:
                next_st.gpr_data = {20'h0, i_fp_control_status_register[11:7], 4'h0,
                                    i_fp_control_status_register[24], i_fp_control_status_register[1:0]};
              `FCC_SEL_CSR: next_st.gpr_data = i_fp_control_status_register;
              // Undefined selector: zero, software must not rely on it
              default: next_st.gpr_data = 32'h00000000;
            endcase
          end
          FCC_OP_NONE: begin
            // Unknown FP encoding inside this slice
            next_st.done = 1'b0;
          end
          default: begin
            next_st.exc_ri = 1'b1;
          end
        endcase
      end
    end
  end

  // State register, synchronous reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st <= '0;
      st.op <= FCC_OP_NONE;
    end else begin
      st <= next_st;
    end
  end

  assign o_done = st.done;
  assign o_op = st.op;
  assign o_fpr_we = st.fpr_we;
  assign o_fpr_addr = st.fpr_addr;
  assign o_fpr_data = st.fpr_data;
  assign o_gpr_we = st.gpr_we;
  assign o_gpr_addr = st.gpr_addr;
  assign o_gpr_data = st.gpr_data;
  assign o_fp_control_status_register_we = st.fp_control_status_register_we;
  assign o_fp_control_status_register_next = st.fp_control_status_register_next;
  assign o_exc_cop_unusable = st.exc_cu;
  assign o_exc_reserved = st.exc_ri;
  assign o_exc_invalid = st.exc_inv;
  assign o_exc_unimpl = st.exc_uni;

  // Invalid trap never writes the destination
  trap_no_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_exc_invalid |-> !o_fpr_we) else $error("trap wrote fpr");

  // Invalid conversion without enable gives max int64
  sat_long_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && i_fp_coprocessor_major_opcode_usable && dec_op == FCC_OP_ROUND_UP_TO_INT64 && i_fr64
     && cv_invalid && !i_fp_control_status_register[`FCC_BIT_INV_EN])
    |=> o_fpr_we && o_fpr_data == 64'h7FFFFFFFFFFFFFFF)
    else $error("bad int64 default");

  // Same for the word form
  sat_word_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && i_fp_coprocessor_major_opcode_usable && dec_op == FCC_OP_ROUND_UP_TO_INT32
     && cv_invalid && !i_fp_control_status_register[`FCC_BIT_INV_EN])
    |=> o_fpr_we && o_fpr_data[31:0] == 32'h7FFFFFFF)
    else $error("bad int32 default");

  // Invalid flag raised after an invalid word conversion
  inv_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && i_fp_coprocessor_major_opcode_usable && dec_op == FCC_OP_ROUND_UP_TO_INT32 && cv_invalid)
    |=> o_fp_control_status_register_we && o_fp_control_status_register_next[6]) else $error("no invalid flag");

  // Selector 31 copies status word
  sel_full_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && i_fp_coprocessor_major_opcode_usable && dec_op == FCC_OP_READ_CTL
     && i_instr[15:11] == 5'd31) |=> o_gpr_we && o_gpr_data == $past(i_fp_control_status_register))
    else $error("bad full read");

  // Selector 25 view
  sel_cc_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && i_fp_coprocessor_major_opcode_usable && dec_op == FCC_OP_READ_CTL
     && i_instr[15:11] == 5'd25) |=> o_gpr_data[31:8] == 24'h0)
    else $error("bad cc view");

  // Selector 0 reads implementation register
  sel_fir_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && i_fp_coprocessor_major_opcode_usable && dec_op == FCC_OP_READ_CTL
     && i_instr[15:11] == 5'd0) |=> o_gpr_data == 32'h00000000)
    else $error("bad fir read");

  // Positive fractions round up
  round_up_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && i_fp_coprocessor_major_opcode_usable && dec_op == FCC_OP_ROUND_UP_TO_INT32
     && f_fmt == 5'h10 && i_fs_value[31:0] == 32'h3FC00000)
    |=> o_fpr_data[31:0] == 32'h00000002) else $error("no round up");
endmodule

// >>> test/fcc_fp_control_status_register_model.sv
`timescale 1ns/10ps
// Issue-side holder of the status register word
module fcc_fp_control_status_register_model (
  // Clock
  input wire logic i_clk,
  // Bench load
  input wire logic i_load,
  input wire logic [31:0] i_load_value,
  // Block update
  input wire logic i_fp_control_status_register_we,
  input wire logic [31:0] i_fp_control_status_register_next,
  // Current value
  output logic [31:0] o_fp_control_status_register
);
  logic [31:0] held = 32'h0; // Last committed word
  // Bench load wins, so every issue sees a known word
  assign o_fp_control_status_register = i_load ? i_load_value : held;
  // Commit updates as the pipeline would
  always @(posedge i_clk) begin
    if (i_fp_control_status_register_we) begin
      held <= i_fp_control_status_register_next;
    end
  end
endmodule

// >>> test/testbench.sv
`timescale 1ns/10ps
`include "fcc_params.svh"
// Self-checking bench for the conversion and control read slice
module testbench;
  import fcc_pkg::*;
  // Expected outcome of one issue
  typedef struct {
    logic [69:0] fpr;
    logic [37:0] gpr;
    logic [3:0] exc;
    logic fchk;
    logic [31:0] fp_control_status_register;
    fcc_op_t op;
  } fcc_exp_t;
  logic i_clk = 0, i_rst_n = 0, i_valid = 0, i_fp_coprocessor_major_opcode_usable = 1, i_fr64 = 1;
  logic [31:0] i_instr = 32'h0, i_fp_control_status_register, ld_val = 32'h0, r;
  logic [63:0] i_fs_value = 64'h0;
  logic ld = 0;
  logic o_done, o_fpr_we, o_gpr_we, o_fp_control_status_register_we, o_exc_cop_unusable;
  logic o_exc_reserved, o_exc_invalid, o_exc_unimpl;
  logic [4:0] o_fpr_addr, o_gpr_addr;
  logic [63:0] o_fpr_data;
  logic [31:0] o_gpr_data, o_fp_control_status_register_next;
  fcc_op_t o_op;
  int n_mismatch = 0, checks = 0, i;
  integer seed = 32'h053C;
  fcc_exp_t q[$], e, x;
  // Boundary operands: double flag, then bits
  logic [64:0] tab [13] = '{65'h0_ABCD12343FC00000, 65'h0_BFC00000,
    65'h0_40400000, 65'h0_7F800000, 65'h0_7FC00000, 65'h0_4F000000,
    65'h0_CF000000, 65'h0_BF000000, 65'h1_3FF8000000000000,
    65'h1_43E0000000000000, 65'h1_C3E0000000000000,
    65'h1_41DFFFFFFFC00000, 65'h1_41DFFFFFFFE00000};
  logic [4:0] sels [7] = '{5'h00, 5'h19, 5'h1A, 5'h1C, 5'h1F, 5'h05, 5'h1E};

  always #25 i_clk = ~i_clk;

  fcc_top DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(i_valid),
    .i_instr(i_instr), .i_fp_coprocessor_major_opcode_usable(i_fp_coprocessor_major_opcode_usable), .i_fr64(i_fr64),
    .i_fs_value(i_fs_value), .i_fp_control_status_register(i_fp_control_status_register), .o_done(o_done), .o_op(o_op),
    .o_fpr_we(o_fpr_we), .o_fpr_addr(o_fpr_addr), .o_fpr_data(o_fpr_data),
    .o_gpr_we(o_gpr_we), .o_gpr_addr(o_gpr_addr), .o_gpr_data(o_gpr_data),
    .o_fp_control_status_register_we(o_fp_control_status_register_we), .o_fp_control_status_register_next(o_fp_control_status_register_next),
    .o_exc_cop_unusable(o_exc_cop_unusable), .o_exc_reserved(o_exc_reserved),
    .o_exc_invalid(o_exc_invalid), .o_exc_unimpl(o_exc_unimpl));
  fcc_fp_control_status_register_model PM (.i_clk(i_clk), .i_load(ld), .i_load_value(ld_val),
    .i_fp_control_status_register_we(o_fp_control_status_register_we), .i_fp_control_status_register_next(o_fp_control_status_register_next), .o_fp_control_status_register(i_fp_control_status_register));

  // Count and report one comparison
  task automatic chk(input logic [69:0] seen, input logic [69:0] want);
    checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask

  // Verdict and end of run
  task automatic conclude();
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Single bits widened to double; denormal operands are never issued
  function automatic logic [63:0] widen(input logic [31:0] s);
    logic [10:0] ex;
    ex = {3'h0, s[30:23]} + 11'h380;
    if (s[30:23] == 8'hFF) ex = 11'h7FF;
    if (s[30:23] == 8'h00) ex = 11'h000;
    return {s[31], ex, s[22:0], 29'h0};
  endfunction

  // Reference ceiling: invalid, inexact, then the written value
  function automatic logic [65:0] ceil_ref(input logic [63:0] b,
      input logic w);
    real v;
    longint n;
    logic [65:0] bad;
    bad = {2'b10, w ? 64'h000000007FFFFFFF : `FCC_MAX_L};
    v = $bitstoreal(b);
    if (b[62:52] == 11'h7FF) return bad;
    if (w && (v > 2147483647.0 || v <= -2147483649.0)) return bad;
    if (!w && (v >= 2.0 ** 63 || v < -(2.0 ** 63))) return bad;
    n = longint'(v);
    if (real'(n) < v) n++;
    return {1'b0, real'(n) != v, w ? {32'h0, n[31:0]} : n};
  endfunction

  // Present one instruction just after an edge and note its outcome
  task automatic issue(input logic [31:0] ins, input logic [63:0] src,
      input logic [31:0] fc, input logic fr, input logic ok,
      input logic note);
    @(posedge i_clk);
    #2;
    i_valid = 1;
    i_instr = ins;
    i_fs_value = src;
    ld = 1;
    ld_val = fc;
    i_fr64 = fr;
    i_fp_coprocessor_major_opcode_usable = ok;
    if (note) q.push_back(x);
  endtask

  // Ceiling conversion with its expected writes and status update
  task automatic conv(input logic w, input logic dbl, input logic [63:0] s,
      input logic en, input logic fr);
    logic [65:0] c;
    logic [31:0] fc;
    fc = ($random(seed) & 32'hFFFC007F) | {20'h0, en, 11'h0};
    c = ceil_ref(dbl ? s : widen(s[31:0]), w);
    x = '{{1'b1, fc[22:18], c[63:0]}, 38'h0, 4'h0, c[65] | c[64], fc,
      w ? FCC_OP_ROUND_UP_TO_INT32 : FCC_OP_ROUND_UP_TO_INT64};
    if (c[65]) begin
      x.fp_control_status_register = fc | 32'h00010040;
      if (en) begin
        x.exc = 4'h2;
        x.fpr = 70'h0;
      end
    end else if (c[64]) begin
      x.fp_control_status_register = fc | 32'h00001004;
    end
    // Long form with half the register file is refused as unimplemented
    if (!w && !fr) begin
      x = '{70'h0, 38'h0, 4'h1, 1'b1, fc | 32'h00020000, FCC_OP_ROUND_UP_TO_INT64};
    end
    issue({`FCC_OP_FP_COPROCESSOR_MAJOR_OPCODE, dbl ? `FCC_FMT_D : `FCC_FMT_S, 5'h00, fc[26:22],
      fc[22:18], w ? `FCC_FN_ROUND_UP_TO_INT32 : `FCC_FN_ROUND_UP_TO_INT64}, s, fc, fr, 1, 1);
  endtask

  // Control word read through one selector
  task automatic ctl(input logic [4:0] sel);
    logic [31:0] fc, v;
    fc = $random(seed);
    case (sel)
      5'h00: v = `FCC_FIR_VALUE;
      5'h19: v = {24'h0, fc[31:25], fc[23]};
      5'h1A: v = {14'h0, fc[17:12], 5'h0, fc[6:2], 2'h0};
      5'h1C: v = {20'h0, fc[11:7], 4'h0, fc[24], fc[1:0]};
      5'h1F: v = fc;
      default: v = 32'h0;
    endcase
    x = '{70'h0, {1'b1, ~sel, v}, 4'h0, 1'b0, 32'h0, FCC_OP_READ_CTL};
    issue({`FCC_OP_FP_COPROCESSOR_MAJOR_OPCODE, `FCC_SUB_CF, ~sel, sel, 11'h000}, 64'h0, fc, 1, 1, 1);
  endtask

  // Result watcher: any event takes the oldest note
  always @(posedge i_clk) begin
    #1;
    if (o_done | o_exc_cop_unusable | o_exc_reserved | o_exc_invalid |
        o_exc_unimpl) begin
      e = q.size() ? q.pop_front() : fcc_exp_t'{70'h0, 38'h0, 4'hF, 1'b0,
        32'h0, FCC_OP_NONE};
      chk(o_fpr_we ? {o_fpr_we, o_fpr_addr, o_fpr_data} : 70'h0, e.fpr);
      chk(o_gpr_we ? {o_gpr_we, o_gpr_addr, o_gpr_data} : 38'h0, e.gpr);
      chk({o_exc_cop_unusable, o_exc_reserved, o_exc_invalid, o_exc_unimpl}, e.exc);
      if (e.fchk) chk({o_fp_control_status_register_we, o_fp_control_status_register_next}, {1'b1, e.fp_control_status_register});
      if (o_done && !e.exc[3]) chk(o_op, e.op);
    end
  end

  // Watchdog well beyond the expected run
  initial begin
    #(50 * 3000);
    n_mismatch++;
    conclude();
  end

  // Main sequence, issues back to back
  initial begin
    repeat (8) @(posedge i_clk);
    #2 i_rst_n = 1;
    for (i = 0; i < 52; i++) begin
      conv(i[0], tab[i / 4][64], tab[i / 4][63:0], i[1], 1);
    end
    for (i = 0; i < 40; i++) begin
      r = $random(seed);
      if (r[0]) conv(r[1], 1, $realtobits($itor($random(seed)) / 16.0),
        r[2], 1);
      else conv(r[1], 0, {r, r[31], 8'h78 + {2'h0, r[28:23]}, r[22:0]},
        r[2], 1);
    end
    conv(0, 1, 64'h3FF8000000000000, 0, 0);
    conv(1, 0, 64'h000000003FC00000, 0, 0);
    x = '{70'h0, 38'h0, 4'h8, 1'b0, 32'h0, FCC_OP_NONE};
    issue({`FCC_OP_FP_COPROCESSOR_MAJOR_OPCODE, `FCC_FMT_S, 5'h0, 5'h1, 5'h2, `FCC_FN_ROUND_UP_TO_INT32},
      64'h0, 32'h0, 1, 0, 1);
    issue(32'h48000000, 64'h0, 32'h0, 1, 1, 0);
    issue({`FCC_OP_FP_COPROCESSOR_MAJOR_OPCODE, `FCC_FMT_S, 5'h0, 5'h1, 5'h2, 6'h01}, 64'h0,
      32'h0, 1, 1, 0);
    issue({`FCC_OP_FP_COPROCESSOR_MAJOR_OPCODE, `FCC_FMT_D, 5'h3, 5'h1, 5'h2, `FCC_FN_ROUND_UP_TO_INT64},
      64'h0, 32'h0, 1, 1, 0);
    for (i = 0; i < 7; i++) begin
      ctl(sels[i]);
    end
    @(posedge i_clk);
    #2 i_valid = 0;
    ld = 0;
    repeat (3) @(posedge i_clk);
    #2;
    chk(q.size(), 0);
    conclude();
  end
endmodule
